// ===== inc/event_log_defs.svh
// Function
// - Entry holds code, date and time
// - Each stage edge has distinct code
// - Code is channel plus number; hide zero channel
// - Remote path shows only current entry
// - Each remote read of an unread entry advances read pointer
// - Re-read returns last entry, pointer unmoved
// - Local display steps both ways independently
// - Masked events never enter the log
// - Depth defaults to 200 after reset
// - Depth settable from 50 to 2000
// - Depth change empties log, resets pointers
// - Full log overwrites oldest entry
// - Overflowing entry carries overflow marker
// - Time stamps kept at one millisecond
// - Order setting reverses local next/prev stepping; remote reads stay oldest first
// - Scaling setting picks per-unit or primary
// - Unsynchronised times are marked bracketed
`ifndef EVENT_LOG_DEFS_SVH
`define EVENT_LOG_DEFS_SVH
`define DEPTH_DEFAULT 11'h0C8
`define DEPTH_MIN 11'h032
`define DEPTH_MAX 11'h7D0
`define LOG_SLOTS 2048
`define PTR_W 11
`define CHAN_W 6
`define NUM_W 8
`define SOURCES 16
`define SRC_W 4
`define FAULT_W 16
`define DATE_W 24
`define MS_W 27
`define MS_PER_DAY 27'h5265C00
`define CLK_MHZ 125
`define MS_CYCLES (`CLK_MHZ * 1000)
`define MS_CNT_W 17
`define FIFO_DEPTH 16
`define ONE_PTR 11'h001
`define ZERO_PTR 11'h000
`define ZERO_MS 27'h0000000
`endif

// ===== inc/event_log_pkg.sv
`default_nettype none
package event_log_pkg;
  `include "event_log_defs.svh"
  // One incoming event as offered by a source
  typedef struct packed {
    logic [`CHAN_W-1:0] channel;
    logic [`NUM_W-1:0] number;
    logic [`FAULT_W-1:0] fault;
  } event_in_type;
  // One stored log entry (code, date, time, marker)
  typedef struct packed {
    logic [`CHAN_W-1:0] channel;
    logic [`NUM_W-1:0] number;
    logic [`FAULT_W-1:0] fault;
    logic [`DATE_W-1:0] date;
    logic [`MS_W-1:0] ms_of_day;
    logic synced;
    logic overflow_marker;
  } entry_type;
endpackage
`default_nettype wire

// ===== inc/event_stream_if.sv
`default_nettype none
// Event stream between the FIFO and the log core
interface event_stream_if;
  import event_log_pkg::*;
  logic valid;
  logic ready;
  event_in_type data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== rtl/event_fifo.sv
`default_nettype none
module event_fifo import event_log_pkg::*; #(
  parameter int WIDTH = $bits(event_in_type),
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Draining side
  event_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_type;
  fifo_state_type state;
  fifo_state_type next_state;
  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic full;
  logic empty;
  assign empty = state.wr == state.rd;
  // Full when pointers differ only in the wrap bit
  assign full = (state.wr[AW] != state.rd[AW]) && (state.wr[AW-1:0] == state.rd[AW-1:0]);
  assign in_ready_out = !full;
  assign drain.valid = !empty;
  assign drain.data = mem[state.rd[AW-1:0]];
  // Pointer update
  always_comb begin
    next_state = state;
    if (in_valid_in && !full) begin
      next_state.wr = state.wr + 1'b1;
    end
    if (drain.ready && !empty) begin
      next_state.rd = state.rd + 1'b1;
    end
  end
  // Registers and storage write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
    if (in_valid_in && !full) begin
      mem[state.wr[AW-1:0]] <= in_data_in;
    end
  end
  a_fifo_no_overrun: assert property (@(posedge clk_in) disable iff (rst_in)
    full |=> state.wr == $past(state.wr) || $past(drain.ready))
    else $error("fifo written while full");
endmodule // event_fifo
`default_nettype wire

// ===== rtl/ms_timebase.sv
`default_nettype none
module ms_timebase import event_log_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Time loading
  input wire logic load_in,
  input wire logic [`DATE_W-1:0] load_date_in,
  input wire logic [`MS_W-1:0] load_ms_in,
  // Running time
  output logic [`DATE_W-1:0] date_out,
  output logic [`MS_W-1:0] ms_out
);
  typedef struct packed {
    logic [`MS_CNT_W-1:0] div;
    logic [`DATE_W-1:0] date;
    logic [`MS_W-1:0] ms;
  } tb_state_type;
  tb_state_type state;
  tb_state_type next_state;
  logic tick;   // One-cycle millisecond enable
  assign tick = state.div == `MS_CNT_W'(`MS_CYCLES - 1);
  assign date_out = state.date;
  assign ms_out = state.ms;
  // Divider and calendar day counter; one ms granularity
  always_comb begin
    next_state = state;
    next_state.div = tick ? '0 : state.div + 1'b1;
    if (load_in) begin
      next_state.date = load_date_in;
      next_state.ms = load_ms_in;
    end else if (tick) begin
      if (state.ms == `MS_PER_DAY - 1'b1) begin
        next_state.ms = `ZERO_MS;
        next_state.date = state.date + 1'b1;  // Day number; formatting is software's job
      end else begin
        next_state.ms = state.ms + 1'b1;
      end
    end
  end
  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  a_ms_tick_step: assert property (@(posedge clk_in) disable iff (rst_in)
    tick && !load_in && state.ms != `MS_PER_DAY - 1'b1 |=> ms_out == $past(ms_out) + 1'b1)
    else $error("millisecond counter did not step");
endmodule // ms_timebase
`default_nettype wire

// ===== rtl/event_log_ring_buffer.sv
`default_nettype none
module event_log_ring_buffer import event_log_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Event sources, one per line; code set per source by the caller
  input wire logic [`SOURCES-1:0] src_valid_in,
  input wire logic [`SOURCES-1:0][`CHAN_W-1:0] src_channel_in,
  input wire logic [`SOURCES-1:0][`NUM_W-1:0] src_number_in,
  input wire logic [`SOURCES-1:0][`FAULT_W-1:0] src_fault_in,
  input wire logic [`SOURCES-1:0] src_mask_in,
  output logic [`SOURCES-1:0] src_ready_out,
  // Configuration
  input wire logic depth_wr_in,
  input wire logic [`PTR_W-1:0] depth_in,
  input wire logic clear_log_command_in,
  input wire logic order_newest_first_in,
  input wire logic fault_value_scaling_in,
  input wire logic [`FAULT_W-1:0] primary_ratio_in,
  input wire logic clock_synced_in,
  input wire logic time_load_in,
  input wire logic [`DATE_W-1:0] time_date_in,
  input wire logic [`MS_W-1:0] time_ms_in,
  // Remote read path
  input wire logic remote_read_in,
  input wire logic remote_reread_in,
  output logic remote_valid_out,
  output logic remote_empty_out,
  output entry_type remote_entry_out,
  // Local display path
  input wire logic local_next_in,
  input wire logic local_prev_in,
  output entry_type local_entry_out,
  output logic local_show_channel_out,
  output logic local_bracket_time_out,
  output logic [`FAULT_W-1:0] local_fault_out,
  // Status
  output logic [`PTR_W-1:0] count_out,
  output logic [`PTR_W-1:0] depth_out
);
  // Whole control state of the log
  typedef struct packed {
    logic [`PTR_W-1:0] depth;
    logic [`PTR_W-1:0] wr;
    logic [`PTR_W-1:0] oldest;
    logic [`PTR_W-1:0] count;
    logic [`PTR_W-1:0] rd;
    logic [`PTR_W-1:0] unread;
    logic [`PTR_W-1:0] view;
    logic [`SRC_W-1:0] rr;
    logic remote_valid;
    logic remote_empty;
  } log_state_type;
  log_state_type state;
  log_state_type next_state;
  entry_type mem [`LOG_SLOTS];     // Entry storage, sized for the largest depth
  entry_type remote_q;             // Last delivered entry, kept for re-reads
  entry_type local_q;              // Entry under the display cursor
  event_stream_if strm ();         // FIFO to core
  logic [$bits(event_in_type)-1:0] arb_data;
  logic arb_valid;
  logic [`SRC_W-1:0] arb_sel;
  logic fifo_ready;
  logic [`DATE_W-1:0] now_date;
  logic [`MS_W-1:0] now_ms;
  logic write_en;
  logic full;
  logic depth_ok;
  entry_type new_entry;

  // Per-source handshake; masked sources are drained and dropped
  genvar g;
  generate
    for (g = 0; g < `SOURCES; g++) begin : g_src
      assign src_ready_out[g] = src_mask_in[g] || (fifo_ready && arb_sel == `SRC_W'(g) && arb_valid);
    end
  endgenerate

  // Round-robin pick of one unmasked pending source
  always_comb begin
    arb_valid = 1'b0;
    arb_sel = state.rr;
    for (int i = 0; i < `SOURCES; i++) begin
      if (!arb_valid && src_valid_in[4'(state.rr + 4'(i))] && !src_mask_in[4'(state.rr + 4'(i))]) begin
        arb_valid = 1'b1;  // Masked never qualifies
        arb_sel = 4'(state.rr + 4'(i));
      end
    end
    arb_data = {src_channel_in[arb_sel], src_number_in[arb_sel], src_fault_in[arb_sel]};
  end

  // Buffer between sources and log so bursts do not stall protection logic
  event_fifo #(
    .WIDTH($bits(event_in_type)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(arb_valid),
    .in_data_in(arb_data),
    .in_ready_out(fifo_ready),
    .drain(strm.src)
  );

  // Millisecond calendar time
  ms_timebase u_time (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(time_load_in),
    .load_date_in(time_date_in),
    .load_ms_in(time_ms_in),
    .date_out(now_date),
    .ms_out(now_ms)
  );

  assign full = state.count == state.depth;
  assign depth_ok = depth_in >= `DEPTH_MIN && depth_in <= `DEPTH_MAX;
  // Core stalls the FIFO during clear or resize so no entry is lost
  assign strm.ready = !clear_log_command_in && !(depth_wr_in && depth_ok);
  assign write_en = strm.valid && strm.ready;

  // Build stored entry with date and time stamp
  always_comb begin
    new_entry.channel = strm.data.channel;
    new_entry.number = strm.data.number;
    new_entry.fault = strm.data.fault;
    new_entry.date = now_date;
    new_entry.ms_of_day = now_ms;       // Coarse sources simply land on whole ms
    new_entry.synced = clock_synced_in;
    new_entry.overflow_marker = full;   // Newest flagged when oldest is lost
  end

  // Pointer and count logic
  always_comb begin
    next_state = state;
    next_state.rr = arb_valid && fifo_ready ? 4'(arb_sel + 1'b1) : state.rr;
    next_state.remote_valid = 1'b0;  // Pulse ends even when clear or resize swallows the cycle
    if (clear_log_command_in) begin
      // All pointers and the count back to zero in one cycle; depth kept
      next_state.wr = `ZERO_PTR;
      next_state.oldest = `ZERO_PTR;
      next_state.count = `ZERO_PTR;
      next_state.rd = `ZERO_PTR;
      next_state.unread = `ZERO_PTR;
      next_state.view = `ZERO_PTR;
    end else if (depth_wr_in && depth_ok) begin
      // New depth empties the log
      next_state.depth = depth_in;
      next_state.wr = `ZERO_PTR;
      next_state.oldest = `ZERO_PTR;
      next_state.count = `ZERO_PTR;
      next_state.rd = `ZERO_PTR;
      next_state.unread = `ZERO_PTR;
      next_state.view = `ZERO_PTR;
    end else begin
      // Remote read of current entry only
      if (remote_read_in) begin
        next_state.remote_valid = 1'b1;
        next_state.remote_empty = state.unread == `ZERO_PTR;
        if (state.unread != `ZERO_PTR) begin
          next_state.rd = state.rd == state.depth - `ONE_PTR ? `ZERO_PTR : state.rd + `ONE_PTR;
          next_state.unread = state.unread - `ONE_PTR;
        end
      end else if (remote_reread_in) begin
        next_state.remote_valid = 1'b1;  // Same entry again, pointer still
      end
      // Local cursor, independent of the remote pointer
      if ((local_next_in ^ order_newest_first_in) && local_next_in != local_prev_in) begin
        next_state.view = state.view == state.depth - `ONE_PTR ? `ZERO_PTR : state.view + `ONE_PTR;
      end else if (local_next_in != local_prev_in) begin
        next_state.view = state.view == `ZERO_PTR ? state.depth - `ONE_PTR : state.view - `ONE_PTR;
      end
      if (write_en) begin
        next_state.wr = state.wr == state.depth - `ONE_PTR ? `ZERO_PTR : state.wr + `ONE_PTR;
        if (full) begin
          // Oldest is overwritten
          next_state.oldest = state.oldest == state.depth - `ONE_PTR ? `ZERO_PTR : state.oldest + `ONE_PTR;
        end else begin
          next_state.count = state.count + `ONE_PTR;
        end
        // Unread entries follow the oldest when it is lost
        if (state.unread == state.depth) begin
          next_state.rd = next_state.oldest;
        end else if (!(remote_read_in && state.unread != `ZERO_PTR)) begin
          next_state.unread = state.unread + `ONE_PTR;
        end else begin
          next_state.unread = state.unread;
        end
      end
    end
  end

  // State register, storage and output data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0;
      state.depth <= `DEPTH_DEFAULT;
      remote_q <= '0;
      local_q <= '0;
    end else begin
      state <= next_state;
      if (remote_read_in && state.unread != `ZERO_PTR && !clear_log_command_in && !(depth_wr_in && depth_ok)) begin
        remote_q <= mem[state.rd];
      end
      local_q <= mem[state.view];
    end
    if (write_en) begin
      mem[state.wr] <= new_entry;
    end
  end

  // Outputs
  assign remote_valid_out = state.remote_valid;
  assign remote_empty_out = state.remote_empty;
  assign remote_entry_out = remote_q;
  assign local_entry_out = local_q;
  assign local_show_channel_out = local_q.channel != '0;
  assign local_bracket_time_out = !local_q.synced;
  // Primary scaling multiplies per-unit value by the ratio
  assign local_fault_out = fault_value_scaling_in ? `FAULT_W'(local_q.fault * primary_ratio_in) : local_q.fault;
  assign count_out = state.count;
  assign depth_out = state.depth;

  a_reset_depth_default: assert property (@(posedge clk_in)
    $fell(rst_in) |-> depth_out == `DEPTH_DEFAULT)
    else $error("depth not default after reset");
  a_depth_range_kept: assert property (@(posedge clk_in) disable iff (rst_in)
    depth_out >= `DEPTH_MIN && depth_out <= `DEPTH_MAX)
    else $error("depth out of range");
  a_resize_empties_log: assert property (@(posedge clk_in) disable iff (rst_in)
    depth_wr_in && depth_ok && !clear_log_command_in |=> count_out == `ZERO_PTR && depth_out == $past(depth_in))
    else $error("resize did not empty log");
  a_clear_empties_log: assert property (@(posedge clk_in) disable iff (rst_in)
    clear_log_command_in |=> count_out == `ZERO_PTR && state.rd == `ZERO_PTR && state.wr == `ZERO_PTR)
    else $error("clear did not empty log");
  a_read_advances_ptr: assert property (@(posedge clk_in) disable iff (rst_in)
    remote_read_in && state.unread != `ZERO_PTR && !clear_log_command_in && !(depth_wr_in && depth_ok) && !write_en
    |=> state.unread == $past(state.unread) - `ONE_PTR && remote_valid_out)
    else $error("read did not advance");
  a_empty_read_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    remote_read_in && state.unread == `ZERO_PTR && !clear_log_command_in && !(depth_wr_in && depth_ok)
    |=> remote_empty_out && state.rd == $past(state.rd))
    else $error("empty read moved pointer");
  a_reread_holds_ptr: assert property (@(posedge clk_in) disable iff (rst_in)
    remote_reread_in && !remote_read_in && !write_en && !clear_log_command_in && !(depth_wr_in && depth_ok)
    |=> state.rd == $past(state.rd) && remote_entry_out == $past(remote_entry_out))
    else $error("reread changed state");
  a_overflow_marks_new: assert property (@(posedge clk_in) disable iff (rst_in)
    write_en && full |=> count_out == $past(count_out) && mem[$past(state.wr)].overflow_marker)
    else $error("overflow not handled");
  a_masked_not_taken: assert property (@(posedge clk_in) disable iff (rst_in)
    arb_valid |-> !src_mask_in[arb_sel])
    else $error("masked source selected");
endmodule // event_log_ring_buffer
`default_nettype wire

// ===== tb/remote_poller.sv
`default_nettype none
module remote_poller import event_log_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Requests towards the log
  output logic remote_read_out,
  output logic remote_reread_out,
  // Answers from the log
  input wire logic remote_valid_in,
  input wire logic remote_empty_in,
  input wire entry_type remote_entry_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet link until the first poll
  initial begin
    remote_read_out = 1'b0;
    remote_reread_out = 1'b0;
  end
  // One poll: a single-cycle request, answer taken at the edge that samples valid high
  task automatic pop(input logic again, output entry_type e, output logic empty, output logic got);
    while (rst_in === 1'b1) begin
      @(posedge clk_in);
    end
    @(posedge clk_in);
    // Re-read is only issued when the caller sets again
    if (again) begin
      remote_reread_out <= 1'b1;
    end else begin
      remote_read_out <= 1'b1;
    end
    @(posedge clk_in);
    remote_read_out <= 1'b0;
    remote_reread_out <= 1'b0;
    // Valid pulse and entry still stand here, before this edge updates them
    @(posedge clk_in);
    e = remote_entry_in;
    empty = remote_empty_in;
    got = remote_valid_in;
  endtask
endmodule // remote_poller
`default_nettype wire

// ===== tb/event_log_ring_buffer_test.sv
`default_nettype none
module event_log_ring_buffer_test import event_log_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in;
  logic [`SOURCES-1:0] src_valid_in, src_mask_in, src_ready_out;
  logic [`SOURCES-1:0][`CHAN_W-1:0] src_channel_in;
  logic [`SOURCES-1:0][`NUM_W-1:0] src_number_in;
  logic [`SOURCES-1:0][`FAULT_W-1:0] src_fault_in, unused_fault;
  logic depth_wr_in, clear_log_command_in, order_newest_first_in, fault_value_scaling_in;
  logic [`PTR_W-1:0] depth_in, count_out, depth_out;
  logic [`FAULT_W-1:0] primary_ratio_in, local_fault_out;
  logic clock_synced_in, time_load_in, remote_read_in, remote_reread_in;
  logic [`DATE_W-1:0] time_date_in;
  logic [`MS_W-1:0] time_ms_in;
  logic remote_valid_out, remote_empty_out, local_next_in, local_prev_in;
  logic local_show_channel_out, local_bracket_time_out;
  entry_type remote_entry_out, local_entry_out, e;
  logic em, got;
  int err_total = 0;
  int samples_checked = 0;
  // Log under test
  event_log_ring_buffer dut_u (.clk_in(clk_in), .rst_in(rst_in), .src_valid_in(src_valid_in),
    .src_channel_in(src_channel_in), .src_number_in(src_number_in), .src_fault_in(src_fault_in),
    .src_mask_in(src_mask_in), .src_ready_out(src_ready_out), .depth_wr_in(depth_wr_in), .depth_in(depth_in),
    .clear_log_command_in(clear_log_command_in), .order_newest_first_in(order_newest_first_in),
    .fault_value_scaling_in(fault_value_scaling_in), .primary_ratio_in(primary_ratio_in),
    .clock_synced_in(clock_synced_in), .time_load_in(time_load_in), .time_date_in(time_date_in),
    .time_ms_in(time_ms_in), .remote_read_in(remote_read_in), .remote_reread_in(remote_reread_in),
    .remote_valid_out(remote_valid_out), .remote_empty_out(remote_empty_out),
    .remote_entry_out(remote_entry_out), .local_next_in(local_next_in), .local_prev_in(local_prev_in),
    .local_entry_out(local_entry_out), .local_show_channel_out(local_show_channel_out),
    .local_bracket_time_out(local_bracket_time_out), .local_fault_out(local_fault_out),
    .count_out(count_out), .depth_out(depth_out));
  // Remote supervisory reader on the far side
  remote_poller poll_u (.clk_in(clk_in), .rst_in(rst_in), .remote_read_out(remote_read_in),
    .remote_reread_out(remote_reread_in), .remote_valid_in(remote_valid_out),
    .remote_empty_in(remote_empty_out), .remote_entry_in(remote_entry_out));
  // 125 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Single comparison point; unknowns never match
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Offer one event on a source line and hold it until taken
  task automatic ev(input int i, input logic [5:0] ch, input logic [7:0] num);
    int n;
    n = 0;
    @(posedge clk_in);
    src_valid_in[i] <= 1'b1;
    src_channel_in[i] <= ch;
    src_number_in[i] <= num;
    src_fault_in[i] <= {8'h00, num};
    @(negedge clk_in);
    while (src_ready_out[i] !== 1'b1 && n < 100) begin
      n++;
      @(negedge clk_in);
    end
    if (n == 100) chk(96'h0, 96'h1, "source ready");
    @(posedge clk_in);
    src_valid_in[i] <= 1'b0;
  endtask
  // Bounded wait for the stored count, then compare it
  task automatic wait_count(input logic [10:0] exp);
    int n;
    for (n = 0; n < 60 && count_out !== exp; n++) @(negedge clk_in);
    chk(count_out, exp, "count");
  endtask
  // One-cycle pulse: 0 next, 1 prev, 2 depth write, 3 clear, 4 time load
  task automatic pulse(input int k);
    @(posedge clk_in);
    case (k)
      0: local_next_in <= 1'b1;
      1: local_prev_in <= 1'b1;
      2: depth_wr_in <= 1'b1;
      3: clear_log_command_in <= 1'b1;
      default: time_load_in <= 1'b1;
    endcase
    @(posedge clk_in);
    {local_next_in, local_prev_in, depth_wr_in, clear_log_command_in, time_load_in} <= 5'h00;
    // Display and settings land within two edges
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #400us;
    err_total++;
    close_out();
  end
  // Main sequence
  initial begin
    logic [10:0] dv [4];
    logic [10:0] de [4];
    dv = '{11'h031, 11'h7D1, 11'h7D0, 11'h032};
    de = '{11'h0C8, 11'h0C8, 11'h7D0, 11'h032};
    rst_in = 1'b1;
    {src_valid_in, src_mask_in, src_channel_in, src_number_in, src_fault_in, unused_fault} = '0;
    {depth_wr_in, clear_log_command_in, order_newest_first_in, fault_value_scaling_in} = 4'h0;
    {local_next_in, local_prev_in, time_load_in, clock_synced_in} = 4'h0;
    depth_in = 11'h000;
    primary_ratio_in = 16'h0010;
    time_date_in = 24'h00ABCD;
    time_ms_in = 27'h0001234;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(depth_out, 11'h0C8, "reset depth");
    chk(count_out, 11'h000, "reset count");
    poll_u.pop(1'b0, e, em, got);
    chk({got, em}, 2'b11, "empty read");
    pulse(4);
    ev(0, 6'h00, 8'h11);
    wait_count(11'h001);
    clock_synced_in <= 1'b1;
    ev(1, 6'h05, 8'h22);
    wait_count(11'h002);
    // Local cursor to slot 1 and back to slot 0, unsynced entry with zero channel
    pulse(0);
    pulse(1);
    chk(local_entry_out.number, 8'h11, "local first");
    chk({local_show_channel_out, local_bracket_time_out}, 2'b01, "local format");
    chk(local_fault_out, 16'h0011, "per-unit fault");
    fault_value_scaling_in <= 1'b1;
    pulse(0);
    chk(local_entry_out.number, 8'h22, "local next");
    chk({local_show_channel_out, local_bracket_time_out}, 2'b10, "local format 2");
    chk(local_fault_out, 16'h0220, "primary fault");
    order_newest_first_in <= 1'b1;
    pulse(0);
    chk(local_entry_out.number, 8'h11, "newest first step");
    // Remote drain, re-read and empty
    poll_u.pop(1'b0, e, em, got);
    chk({got, em, e.channel, e.number, e.date, e.ms_of_day, e.synced}, {2'b10, 6'h00, 8'h11, 24'h00ABCD,
      27'h0001234, 1'b0}, "oldest entry");
    chk(local_entry_out.number, 8'h11, "local independent");
    poll_u.pop(1'b0, e, em, got);
    chk(e.number, 8'h22, "second entry");
    repeat (2) begin
      poll_u.pop(1'b1, e, em, got);
      chk({got, e.number}, {1'b1, 8'h22}, "re-read");
    end
    poll_u.pop(1'b0, e, em, got);
    chk({got, em}, 2'b11, "drained");
    // Masked source writes nothing
    src_mask_in[3] <= 1'b1;
    ev(3, 6'h01, 8'h33);
    repeat (20) @(posedge clk_in);
    chk(count_out, 11'h002, "masked");
    src_mask_in[3] <= 1'b0;
    // Depth limits; an accepted change empties the log
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      depth_in <= dv[k];
      pulse(2);
      chk(depth_out, de[k], "depth");
      if (k >= 2) chk(count_out, 11'h000, "resize empties");
    end
    // Fill a 50-slot log with 51 events
    for (int i = 0; i <= 50; i++) ev(i % 16, 6'h01, i[7:0]);
    wait_count(11'h032);
    repeat (40) @(posedge clk_in); // let the FIFO run dry
    for (int k = 0; k < 50; k++) begin
      poll_u.pop(1'b0, e, em, got);
      chk(e.number, k[7:0] + 8'h01, "after overwrite");
      chk(e.overflow_marker, k == 49, "overflow marker");
    end
    // Clear empties everything
    ev(2, 6'h02, 8'h44);
    wait_count(11'h032);
    pulse(3);
    chk(count_out, 11'h000, "cleared");
    poll_u.pop(1'b0, e, em, got);
    chk(em, 1'b1, "cleared read");
    close_out();
  end
endmodule // event_log_ring_buffer_test
`default_nettype wire
